// file: src/iie_cfg.svh
`ifndef IIE_CFG_SVH
`define IIE_CFG_SVH

// Opcodes and encodings.
`define IIE_OP_IDLE      8'h6f
`define IIE_OP_INC_R     8'h20
`define IIE_OP_INC_IR    8'h21
`define IIE_LO_INC_WREG  4'he
`define IIE_CYCLES_INC   3'd4
`define IIE_CYCLES_IDLE  3'd4
// Working registers live at this base plus the register number.
`define IIE_WREG_BASE    8'hc0
// Flag bit positions in the 8-bit flag byte.
`define IIE_FLG_C        7
`define IIE_FLG_Z        6
`define IIE_FLG_S        5
`define IIE_FLG_V        4
`define IIE_FLG_D        3
`define IIE_FLG_H        2

`endif

// file: src/iie_exec.sv
`timescale 1ns/1ps
`include "iie_cfg.svh"
// How it works
// RULE_01 - Opcode 6F idles: CPU clock stops, system clock runs, four cycles.
// RULE_02 - An interrupt request ends the idle halt and resumes execution.
// RULE_03 - Idle leaves all flags unchanged.
// RULE_04 - Increment adds one, sets Z on zero, keeps C, D and H.
// RULE_05 - S follows bit 7 of the result.
// RULE_06 - V is set on signed overflow, cleared otherwise.
// RULE_07 - Opcode rE increments working register r in four cycles.
// RULE_08 - Opcode 20 increments the register named by the second byte.
// RULE_09 - Opcode 21 increments the register addressed by the named pointer.
// RULE_10 - Increment wraps FF to 00; V only on 7F to 80.
module iie_exec
  import iie_pkg::*;
(
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Instruction issue.
  input  wire logic       i_start,
  input  wire logic [7:0] i_opcode,
  input  wire logic [7:0] i_operand,
  // Flags and register file.
  input  wire logic [7:0] i_flags,
  input  wire logic [7:0] i_rdata,
  // Interrupt request pin.
  input  wire logic       i_irq,
  // Register file access.
  output iie_regbus_s     o_reg,
  // Flag update.
  output logic [7:0]      o_flags,
  output logic            o_flags_we,
  // Clock gate and status.
  output logic            o_cpu_clk_en,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_illegal
);

  typedef struct packed {
    iie_state_e  st;
    logic [2:0]  cnt;
    logic [7:0]  dst;
    logic        inc;
    iie_regbus_s bus;
    logic [7:0]  flags;
    logic        flags_we;
    logic        clk_en;
    logic        done;
    logic        illegal;
    logic        irq_m;
    logic        irq_s;
    logic        busy;
  } iie_regs_s;

  iie_regs_s r_r;
  iie_regs_s r_nxt;
  iie_alu_s  alu;

  iie_inc8 u_inc (
    .i_value (i_rdata),
    .i_flags (i_flags),
    .o_alu   (alu)
  );

  always_comb begin
    r_nxt = r_r;
    // The request pin is asynchronous to this clock, so it is double-registered.
    r_nxt.irq_m = i_irq;
    r_nxt.irq_s = r_r.irq_m;
    r_nxt.bus.we = 1'b0;
    r_nxt.flags_we = 1'b0;
    r_nxt.done = 1'b0;
    r_nxt.illegal = 1'b0;
    r_nxt.cnt = (r_r.cnt == 3'd0) ? 3'd0 : r_r.cnt - 3'd1;
    unique case (r_r.st)
      IIE_IDLE_ST: begin
        if (i_start) begin
          r_nxt.cnt = `IIE_CYCLES_INC - 3'd1;
          if (i_opcode == `IIE_OP_IDLE) begin
            r_nxt.cnt = `IIE_CYCLES_IDLE - 3'd1;                    // RULE_01
            r_nxt.inc = 1'b0;
            r_nxt.st  = IIE_OPER;
          end else if (i_opcode[3:0] == `IIE_LO_INC_WREG) begin
            r_nxt.dst = `IIE_WREG_BASE | {4'h0, i_opcode[7:4]};     // RULE_07
            r_nxt.bus.addr = `IIE_WREG_BASE | {4'h0, i_opcode[7:4]};
            r_nxt.inc = 1'b1;
            r_nxt.st  = IIE_DST_RD;
          end else if (i_opcode == `IIE_OP_INC_R) begin
            r_nxt.dst = i_operand;                                  // RULE_08
            r_nxt.bus.addr = i_operand;
            r_nxt.inc = 1'b1;
            r_nxt.st  = IIE_DST_RD;
          end else if (i_opcode == `IIE_OP_INC_IR) begin
            r_nxt.bus.addr = i_operand;                             // RULE_09
            r_nxt.inc = 1'b1;
            r_nxt.st  = IIE_PTR_RD;
          end else begin
            r_nxt.illegal = 1'b1;
            r_nxt.done = 1'b1;
          end
        end
      end
      IIE_OPER: begin
        // Idle: the flag write strobe stays low so no flag moves.
        r_nxt.clk_en = 1'b0;                                        // RULE_01 RULE_03
        r_nxt.st = IIE_HALTED;
      end
      IIE_PTR_RD: begin
        // Pointer is only read; the increment lands on what it points to.
        r_nxt.dst = i_rdata;                                        // RULE_09
        r_nxt.bus.addr = i_rdata;
        r_nxt.st = IIE_DST_RD;
      end
      IIE_DST_RD: begin
        r_nxt.bus.wdata = alu.result;                               // RULE_10
        r_nxt.bus.addr = r_r.dst;
        r_nxt.bus.we = 1'b1;
        r_nxt.flags = alu.flags;                                    // RULE_04 RULE_05 RULE_06
        r_nxt.flags_we = 1'b1;
        r_nxt.st = IIE_WRITE;
      end
      IIE_WRITE: begin
        if (r_r.cnt == 3'd0) begin
          r_nxt.done = 1'b1;
          r_nxt.st = IIE_IDLE_ST;
        end
      end
      IIE_HALTED: begin
        if (r_r.irq_s) begin
          r_nxt.clk_en = 1'b1;                                      // RULE_02
          r_nxt.st = IIE_DONE;
        end
      end
      IIE_DONE: begin
        r_nxt.done = 1'b1;
        r_nxt.st = IIE_IDLE_ST;
      end
      default: begin
        r_nxt.st = IIE_IDLE_ST;
      end
    endcase
    // Busy is registered from the next state so the port comes straight from a flop.
    r_nxt.busy = (r_nxt.st != IIE_IDLE_ST);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r_r <= '{st: IIE_IDLE_ST, clk_en: 1'b1, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_reg        = r_r.bus;
  assign o_flags      = r_r.flags;
  assign o_flags_we   = r_r.flags_we;
  assign o_cpu_clk_en = r_r.clk_en;
  assign o_busy       = r_r.busy;
  assign o_done       = r_r.done;
  assign o_illegal    = r_r.illegal;

endmodule

// file: src/iie_inc8.sv
`timescale 1ns/1ps
`include "iie_cfg.svh"
module iie_inc8
  import iie_pkg::*;
(
  // Operand.
  input  wire logic [7:0] i_value,
  input  wire logic [7:0] i_flags,
  // Result.
  output iie_alu_s        o_alu
);

  logic [7:0] sum;

  always_comb begin
    sum = i_value + 8'h01;
    o_alu.result = sum;
    o_alu.flags = i_flags;
    o_alu.flags[`IIE_FLG_Z] = (sum == 8'h00);                        // RULE_04
    o_alu.flags[`IIE_FLG_S] = sum[7];                                // RULE_05
    o_alu.flags[`IIE_FLG_V] = (i_value == 8'h7f);                    // RULE_06
    // Carry, decimal-adjust and half-carry pass through from i_flags.
    o_alu.flags[`IIE_FLG_C] = i_flags[`IIE_FLG_C];                   // RULE_10
  end

endmodule

// file: src/iie_pkg.sv
package iie_pkg;

  typedef enum logic [2:0] {
    IIE_IDLE_ST  = 3'b000,
    IIE_OPER     = 3'b001,
    IIE_PTR_RD   = 3'b011,
    IIE_DST_RD   = 3'b010,
    IIE_WRITE    = 3'b110,
    IIE_HALTED   = 3'b111,
    IIE_DONE     = 3'b101
  } iie_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } iie_regbus_s;

  typedef struct packed {
    logic [7:0] result;
    logic [7:0] flags;
  } iie_alu_s;

endpackage

// file: tb/iie_exec_assertions.sv
`timescale 1ns/1ps
module iie_exec_assertions
  import iie_pkg::*;
(
  // Watched ports.
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_start,
  input wire logic       o_busy,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_operand,
  input wire logic       i_irq,
  input wire iie_regbus_s o_reg,
  input wire logic [7:0] o_flags,
  input wire logic       o_flags_we,
  input wire logic       o_cpu_clk_en,
  input wire logic       o_done
);
  logic tk;
  logic inc;
  logic inc_q;
  assign tk = i_start & ~o_busy;
  assign inc = (i_opcode[3:0] == 4'he) || (i_opcode[7:1] == 7'h10);
  // Remembers the kind of the running instruction so flag checks skip idle and illegal ends.
  always_ff @(posedge i_clk) begin
    if (i_reset) inc_q <= 1'b0;
    else if (tk) inc_q <= inc;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_gate; tk && i_opcode == 8'h6f |-> ##2 !o_cpu_clk_en; endproperty
  a_gate: assert property (p_gate) else $error("clock not gated");
  property p_wake; !o_cpu_clk_en && i_irq |-> ##[1:4] o_cpu_clk_en; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_idfl; !o_cpu_clk_en |-> !o_flags_we; endproperty
  a_idfl: assert property (p_idfl) else $error("idle wrote flags");
  property p_done; tk && inc |-> ##5 o_done; endproperty
  a_done: assert property (p_done) else $error("done late");
  property p_z; o_done && inc_q |-> o_flags[6] == (o_reg.wdata == 8'h00); endproperty
  a_z: assert property (p_z) else $error("zero flag");
  property p_s; o_done && inc_q |-> o_flags[5] == o_reg.wdata[7]; endproperty
  a_s: assert property (p_s) else $error("sign flag");
  property p_v; o_done && inc_q |-> o_flags[4] == (o_reg.wdata == 8'h80); endproperty
  a_v: assert property (p_v) else $error("overflow flag");
  property p_ptr; tk && i_opcode == 8'h21 |=> o_reg.addr == $past(i_operand); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer address");
endmodule
bind iie_exec iie_exec_assertions i_chk (.i_clk, .i_reset, .i_start, .o_busy, .i_opcode, .i_operand,
  .i_irq, .o_reg, .o_flags, .o_flags_we, .o_cpu_clk_en, .o_done);

// file: tb/iie_exec_tb_top.sv
`timescale 1ns/1ps
module iie_exec_tb_top;
  import iie_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_start = 1'b0;
  logic        i_irq = 1'b0;
  logic [7:0]  i_opcode = 8'h00;
  logic [7:0]  i_operand = 8'h00;
  logic [7:0]  i_flags = 8'hfc;
  logic [7:0]  i_rdata;
  logic [7:0]  o_flags;
  logic [7:0]  e;
  logic [7:0]  mem [256];
  iie_regbus_s o_reg;
  logic        o_flags_we, o_cpu_clk_en, o_busy, o_done;
  logic        o_illegal, ill;
  int          miscompares = 0;
  int          total_checks = 0;
  int          nfw = 0;
  iie_exec i_iie_exec (.i_clk, .i_reset, .i_start, .i_opcode, .i_operand, .i_flags, .i_rdata,
    .i_irq, .o_reg, .o_flags, .o_flags_we, .o_cpu_clk_en, .o_busy, .o_done, .o_illegal);
  assign i_rdata = mem[o_reg.addr];
  always @(posedge i_clk) begin
    if (o_reg.we) mem[o_reg.addr] <= o_reg.wdata;
    if (o_flags_we) nfw++;
  end
  initial forever #12.5 i_clk = ~i_clk;
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic go(input logic [7:0] op, input logic [7:0] d);
    int n;
    @(negedge i_clk);
    i_start = 1'b1;
    i_opcode = op;
    i_operand = d;
    @(negedge i_clk);
    i_start = 1'b0;
    for (n = 0; n < 50 && o_done !== 1'b1; n++) @(negedge i_clk);
    chk("done", 8'h01, {7'h00, o_done});
    chk("busy", 8'h00, {7'h00, o_busy});
    ill = o_illegal;
  endtask
  task automatic results();
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The run needs about 130 cycles, so four thousand means a hang.
  initial begin
    #100000;
    miscompares++;
    results();
  end
  initial begin
    repeat (12) @(negedge i_clk);
    i_reset = 1'b0;
    for (int r = 0; r < 16; r++) begin
      mem[8'hc0 + r] = {r[3:0], 4'hf};
      go({r[3:0], 4'he}, 8'h00);
      e = {r[3:0], 4'hf} + 8'h01;
      chk("wreg", e, mem[8'hc0 + r]);
      chk("flags", {1'b1, e == 8'h00, e[7], e == 8'h80, 4'hc}, o_flags & 8'hfc);
    end
    mem[3] = 8'hff;
    go(8'h20, 8'h03);
    chk("reg", 8'h00, mem[3]);
    mem[8'h10] = 8'h40;
    mem[8'h40] = 8'h0f;
    go(8'h21, 8'h10);
    chk("legal", 8'h00, {7'h00, ill});
    chk("target", 8'h10, mem[8'h40]);
    chk("pointer", 8'h40, mem[8'h10]);
    go(8'h00, 8'h00);
    chk("illegal", 8'h01, {7'h00, ill});
    e = nfw[7:0];
    fork
      go(8'h6f, 8'h00);
      begin
        repeat (6) @(negedge i_clk);
        chk("gated", 8'h00, {7'h00, o_cpu_clk_en});
        i_irq = 1'b1;
      end
    join
    i_irq = 1'b0;
    chk("woken", 8'h01, {7'h00, o_cpu_clk_en});
    chk("idle flag writes", e, nfw[7:0]);
    results();
  end
endmodule
